// ### core/taxe_exec.sv
`timescale 1ns/100ps
// Operation
// - Table read opcode; low two bits pick none, post-inc, post-dec, pre-inc.
// - Table read loads program byte at pointer into latch; pre-inc first.
// - Pointer is a 21-bit byte address over two megabytes.
// - Pointer bit zero picks low or high byte of a word.
// - Table write copies latch to holding register picked by pointer 2:0.
// - Table write uses the same four pointer modes.
// - Table write only updates the selected holding register.
// - Table ops and test-skip leave status flags unchanged.
// - Test-skip decodes bank bit and address; zero discards next word.
// - Skip takes two cycles, three when next instruction is two words.
// - Bank bit zero forces access bank, one uses bank select.
// - Xor-literal puts working register xor immediate into working reg.
// - Xor-file computes working register xor addressed register.
// - Direction zero writes working register, one writes the file.
// - Both xor ops update negative and zero flags only.
module taxe_exec #(
    parameter int PTR_W  = taxe_pkg::PTR_W,
    parameter int HOLD_N = taxe_pkg::HOLD_N
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    // Instruction stream, one word per instruction cycle
    input  wire logic                   cyc_en,
    input  wire logic [15:0]            instr,
    input  wire logic                   next_two_word,
    // Core state
    input  wire logic [7:0]             wreg_in,
    input  wire logic [3:0]             bank_select_register,
    input  wire logic [7:0]             rf_rdata,
    // Program memory read port, combinational
    output logic      [PTR_W-2:0]       pm_word_addr,
    input  wire logic [15:0]            pm_word,
    // Register file address for the current operand
    output logic      [11:0]            rf_raddr,
    // Results
    output logic      [7:0]             wreg_out,
    output logic                        wreg_we,
    output taxe_pkg::taxe_rf_req_t      rf_req,
    output taxe_pkg::taxe_flag_t        flag_upd,
    output logic                        discard,
    output logic                        busy,
    output logic      [PTR_W-1:0]       table_pointer,
    output logic      [7:0]             table_latch,
    output logic      [HOLD_N*8-1:0]    hold_bytes
);
    taxe_pkg::taxe_state_t  state_reg, state_next;
    logic [PTR_W-1:0]       ptr_reg, ptr_next;
    logic [7:0]             lat_reg, lat_next;
    logic [7:0]             hold_reg [HOLD_N];
    logic [7:0]             hold_next [HOLD_N];
    logic [1:0]             mode_reg, mode_next;
    logic                   wr_reg, wr_next;
    logic [7:0]             w_reg, w_next;
    logic                   wwe_reg, wwe_next;
    taxe_pkg::taxe_rf_req_t rf_reg, rf_next;
    taxe_pkg::taxe_flag_t   fl_reg, fl_next;
    logic                   dis_reg, dis_next;
    logic                   busy_reg, busy_next;
    logic [PTR_W-1:0]       acc_ptr;
    logic [7:0]             xres;
    logic                   is_rd, is_wr, is_tst, is_xl, is_xf;

    // Pointer step, sized to the pointer so it wraps on its own
    localparam logic [PTR_W-1:0] PTR_STEP = PTR_W'(1);

    // Opcode decode, acted on only in an idle slot
    assign is_rd  = instr[15:2] == taxe_pkg::TBL_RD_PAT;
    assign is_wr  = instr[15:2] == taxe_pkg::TBL_WR_PAT;
    assign is_tst = instr[15:9] == taxe_pkg::TSTZ_PAT;
    assign is_xl  = instr[15:8] == taxe_pkg::XORL_PAT;
    assign is_xf  = instr[15:10] == taxe_pkg::XORF_PAT;

    // Operand bank: access bank or bank select
    // Combinational so the file data returns in the same slot
    always_comb begin
        if (instr[taxe_pkg::F_BANK]) begin
            rf_raddr = {bank_select_register, instr[7:0]};
        end else begin
            rf_raddr = {taxe_pkg::ACCESS_BANK, instr[7:0]};
        end
    end

    // Pointer seen by the access: bumped first in pre-increment
    // Same bumped value becomes the final pointer, so it moves only once
    assign acc_ptr = (mode_reg == taxe_pkg::PM_PREINC)
                   ? ptr_reg + PTR_STEP : ptr_reg;
    // Word address only; bit zero picks the byte on return
    assign pm_word_addr = acc_ptr[PTR_W-1:1];
    assign xres = wreg_in ^ (is_xl ? instr[7:0] : rf_rdata);

    // Next state of the sequencer and datapath
    always_comb begin
        state_next = state_reg;
        ptr_next   = ptr_reg;
        lat_next   = lat_reg;
        mode_next  = mode_reg;
        wr_next    = wr_reg;
        w_next     = w_reg;
        wwe_next   = 1'b0;
        rf_next    = '0;
        fl_next    = '0;
        dis_next   = 1'b0;
        for (int i = 0; i < HOLD_N; i++) begin
            hold_next[i] = hold_reg[i];
        end
        if (cyc_en) begin
            unique case (state_reg)
                taxe_pkg::TAXE_IDLE: begin
                    if (is_rd || is_wr) begin
                        // Mode and direction kept for the second slot
                        mode_next  = instr[1:0];
                        wr_next    = is_wr;
                        state_next = taxe_pkg::TAXE_TBL2;
                    end else if (is_tst) begin
                        // Zero drops the next word; long ones cost a slot
                        if (rf_rdata == 8'h00) begin
                            dis_next   = 1'b1;
                            state_next = next_two_word
                                ? taxe_pkg::TAXE_SKIP2
                                : taxe_pkg::TAXE_SKIP1;
                        end
                    end else if (is_xl ||
                                 (is_xf && !instr[taxe_pkg::F_DIR])) begin
                        // Xor into the working register
                        w_next   = xres;
                        wwe_next = 1'b1;
                        fl_next  = '{we: 1'b1, n: xres[7],
                                     z: xres == 8'h00};
                    end else if (is_xf) begin
                        // Xor written back to the addressed register
                        rf_next  = '{we: 1'b1, addr: rf_raddr,
                                     wdata: xres};
                        fl_next  = '{we: 1'b1, n: xres[7],
                                     z: xres == 8'h00};
                    end
                end
                taxe_pkg::TAXE_TBL2: begin
                    // Second slot; its instruction word is ignored
                    if (wr_reg) begin
                        hold_next[acc_ptr[2:0]] = lat_reg;
                    end else begin
                        lat_next = acc_ptr[0] ? pm_word[15:8]
                                              : pm_word[7:0];
                    end
                    unique case (mode_reg)
                        taxe_pkg::PM_NONE:    ptr_next = ptr_reg;
                        taxe_pkg::PM_POSTINC: ptr_next = ptr_reg + PTR_STEP;
                        taxe_pkg::PM_POSTDEC: ptr_next = ptr_reg - PTR_STEP;
                        taxe_pkg::PM_PREINC:  ptr_next = acc_ptr;
                    endcase
                    state_next = taxe_pkg::TAXE_IDLE;
                end
                taxe_pkg::TAXE_SKIP2: begin
                    // First word of a long instruction dropped
                    dis_next   = 1'b1;
                    state_next = taxe_pkg::TAXE_SKIP1;
                end
                taxe_pkg::TAXE_SKIP1: begin
                    // Last discarded slot
                    state_next = taxe_pkg::TAXE_IDLE;
                end
            endcase
        end
        // Busy follows the state, registered so the output is a flop
        busy_next = state_next != taxe_pkg::TAXE_IDLE;
    end

    // State registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= taxe_pkg::TAXE_IDLE;
            ptr_reg   <= taxe_pkg::PTR_RST;
            lat_reg   <= taxe_pkg::BYTE_RST;
            mode_reg  <= taxe_pkg::PM_NONE;
            wr_reg    <= 1'b0;
            w_reg     <= taxe_pkg::BYTE_RST;
            wwe_reg   <= 1'b0;
            rf_reg    <= '0;
            fl_reg    <= '0;
            dis_reg   <= 1'b0;
            busy_reg  <= 1'b0;
            for (int i = 0; i < HOLD_N; i++) begin
                hold_reg[i] <= taxe_pkg::BYTE_RST;
            end
        end else begin
            state_reg <= state_next;
            ptr_reg   <= ptr_next;
            lat_reg   <= lat_next;
            mode_reg  <= mode_next;
            wr_reg    <= wr_next;
            w_reg     <= w_next;
            wwe_reg   <= wwe_next;
            rf_reg    <= rf_next;
            fl_reg    <= fl_next;
            dis_reg   <= dis_next;
            busy_reg  <= busy_next;
            for (int i = 0; i < HOLD_N; i++) begin
                hold_reg[i] <= hold_next[i];
            end
        end
    end

    // Registered outputs
    always_comb begin
        for (int i = 0; i < HOLD_N; i++) begin
            hold_bytes[i*8 +: 8] = hold_reg[i];
        end
    end
    assign wreg_out      = w_reg;
    assign wreg_we       = wwe_reg;
    assign rf_req        = rf_reg;
    assign flag_upd      = fl_reg;
    assign discard       = dis_reg;
    assign busy          = busy_reg;
    assign table_pointer = ptr_reg;
    assign table_latch   = lat_reg;
endmodule // taxe_exec

// ### core/taxe_pkg.sv
package taxe_pkg;
    // Opcode patterns
    localparam logic [13:0] TBL_RD_PAT  = 14'h0002;  // 0000 0000 0000 10 (nn)
    localparam logic [13:0] TBL_WR_PAT  = 14'h0003;  // 0000 0000 0000 11 (nn)
    localparam logic [6:0]  TSTZ_PAT    = 7'h33;     // 0110 011 (a f)
    localparam logic [7:0]  XORL_PAT    = 8'h0a;     // 0000 1010 (k)
    localparam logic [5:0]  XORF_PAT    = 6'h06;     // 0001 10 (d a f)
    // Field positions
    localparam int          F_DIR       = 9;
    localparam int          F_BANK      = 8;
    // Pointer modes
    localparam logic [1:0]  PM_NONE     = 2'h0;
    localparam logic [1:0]  PM_POSTINC  = 2'h1;
    localparam logic [1:0]  PM_POSTDEC  = 2'h2;
    localparam logic [1:0]  PM_PREINC   = 2'h3;
    // Widths and reset values
    localparam int          PTR_W       = 21;
    localparam int          HOLD_N      = 8;
    localparam logic [20:0] PTR_RST     = 21'h00_0000;
    localparam logic [7:0]  BYTE_RST    = 8'h00;
    localparam logic [3:0]  ACCESS_BANK = 4'h0;

    typedef enum logic [1:0] {
        TAXE_IDLE,
        TAXE_TBL2,
        TAXE_SKIP1,
        TAXE_SKIP2
    } taxe_state_t;

    // Register file request
    typedef struct packed {
        logic        we;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } taxe_rf_req_t;

    // Status flag update
    typedef struct packed {
        logic we;
        logic n;
        logic z;
    } taxe_flag_t;
endpackage

// ### verif/taxe_exec_chk.sv
`timescale 1ns/100ps
module taxe_exec_chk #(
    parameter int PTR_W = 21
) (
    // Clock and reset
    input wire logic                   clk,
    input wire logic                   arst_n,
    // Stimulus side
    input wire logic                   cyc_en,
    input wire logic [15:0]            instr,
    input wire logic [7:0]             wreg_in,
    input wire logic [3:0]             bank_select_register,
    input wire logic [7:0]             rf_rdata,
    // Results
    input wire logic [11:0]            rf_raddr,
    input wire logic [7:0]             wreg_out,
    input wire logic                   wreg_we,
    input wire taxe_pkg::taxe_rf_req_t rf_req,
    input wire taxe_pkg::taxe_flag_t   flag_upd,
    input wire logic                   discard,
    input wire logic                   busy,
    input wire logic [PTR_W-1:0]       table_pointer
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Accepted slot decode and xor result
    logic       go, xl, xf, tz, tb;
    logic [7:0] xr;
    assign go = cyc_en && !busy;
    assign xl = go && instr[15:8] == taxe_pkg::XORL_PAT;
    assign xf = go && instr[15:10] == taxe_pkg::XORF_PAT;
    assign tz = go && instr[15:9] == taxe_pkg::TSTZ_PAT;
    assign tb = go && instr[15:4] == 12'h000 && instr[3];
    assign xr = wreg_in ^ (xl ? instr[7:0] : rf_rdata);
    property p_xl; xl |=> wreg_we && wreg_out == $past(xr); endproperty
    a_xl: assert property (p_xl)
        else $error("xor literal result wrong");
    property p_fl; xl || xf |=> flag_upd.we && flag_upd.n == $past(xr[7])
        && flag_upd.z == ($past(xr) == 8'h00); endproperty
    a_fl: assert property (p_fl)
        else $error("xor flags wrong");
    property p_xw; xf && !instr[9] |=> wreg_we && !rf_req.we
        && wreg_out == $past(xr); endproperty
    a_xw: assert property (p_xw)
        else $error("xor file to working register wrong");
    property p_xf; xf && instr[9] |=> rf_req.we && !wreg_we
        && rf_req.wdata == $past(xr) && rf_req.addr == $past(rf_raddr);
    endproperty
    a_xf: assert property (p_xf)
        else $error("xor file write back wrong");
    property p_bk; xf || tz |-> rf_raddr ==
        {instr[8] ? bank_select_register : 4'h0, instr[7:0]}; endproperty
    a_bk: assert property (p_bk)
        else $error("operand bank wrong");
    property p_sk; tz && rf_rdata == 8'h00 |=> discard && busy
        && !flag_upd.we; endproperty
    a_sk: assert property (p_sk)
        else $error("zero test did not skip");
    property p_ns; tz && rf_rdata != 8'h00 |=> !discard && !busy; endproperty
    a_ns: assert property (p_ns)
        else $error("nonzero test skipped");
    property p_tb; tb |=> busy && !flag_upd.we && $stable(table_pointer);
    endproperty
    a_tb: assert property (p_tb)
        else $error("table op first cycle wrong");
    property p_pt; $changed(table_pointer) |-> $past(busy && cyc_en);
    endproperty
    a_pt: assert property (p_pt)
        else $error("pointer moved outside table op");
endmodule // taxe_exec_chk

bind taxe_exec taxe_exec_chk #(.PTR_W(PTR_W)) taxe_exec_chk_i (.clk, .arst_n,
    .cyc_en, .instr, .wreg_in, .bank_select_register, .rf_rdata, .rf_raddr,
    .wreg_out, .wreg_we, .rf_req, .flag_upd, .discard, .busy, .table_pointer);

// ### verif/taxe_exec_bench.sv
`timescale 1ns/100ps
module taxe_exec_bench;
    // Design ports
    logic                   clk = 1'b0, arst_n = 1'b0, cyc_en = 1'b0;
    logic                   next_two_word = 1'b0, wreg_we, discard, busy;
    logic [15:0]            instr = 16'h0000, pm_word;
    logic [7:0]             wreg_in = 8'h00, rf_rdata = 8'h00;
    logic [7:0]             wreg_out, table_latch;
    logic [3:0]             bank_select_register = 4'h7;
    logic [19:0]            pm_word_addr;
    logic [11:0]            rf_raddr;
    logic [20:0]            table_pointer;
    logic [63:0]            hold_bytes;
    taxe_pkg::taxe_rf_req_t rf_req;
    taxe_pkg::taxe_flag_t   flag_upd;
    int                     error_cnt = 0, num_checks = 0;
    // Clock and program memory pattern
    always #50 clk = ~clk;
    assign pm_word = {pm_word_addr[7:0] ^ 8'ha5, pm_word_addr[7:0]};
    taxe_exec taxe_exec_i (
        .clk(clk), .arst_n(arst_n), .cyc_en(cyc_en), .instr(instr),
        .next_two_word(next_two_word), .wreg_in(wreg_in),
        .bank_select_register(bank_select_register), .rf_rdata(rf_rdata),
        .pm_word_addr(pm_word_addr), .pm_word(pm_word),
        .rf_raddr(rf_raddr), .wreg_out(wreg_out), .wreg_we(wreg_we),
        .rf_req(rf_req), .flag_upd(flag_upd), .discard(discard),
        .busy(busy), .table_pointer(table_pointer),
        .table_latch(table_latch), .hold_bytes(hold_bytes));
    // Compare and count
    task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // One instruction slot, results settled after the taking edge
    task automatic slot(logic [15:0] w, logic [7:0] wv, rv, logic nt);
        @(posedge clk);
        cyc_en <= 1'b1;
        {instr, wreg_in, rf_rdata, next_two_word} <= {w, wv, rv, nt};
        @(posedge clk);
        cyc_en <= 1'b0;
        #1;
    endtask
    task automatic t_xor;
        logic [7:0]  k, r;
        logic [11:0] x;
        for (int i = 0; i < 4; i++) begin
            k = 8'haf ^ (8'h1a << i);
            r = 8'hb5 ^ k;
            slot({8'h0a, k}, 8'hb5, 8'h00, 1'b0);
            x = {2'b11, r[7], r == 8'h00, r};
            check("xl", {wreg_we, flag_upd, wreg_out}, x);
            slot({6'h06, i[1:0], 8'h3c}, 8'hb5, 8'haf, 1'b0);
            check("xf", {wreg_we, rf_req.we, flag_upd},
                {~i[1], i[1], 3'b100});
            check("xfres", i[1] ? rf_req.wdata : wreg_out, 8'h1a);
            check("xfadr", rf_raddr, {i[0] ? 4'h7 : 4'h0, 8'h3c});
            x = i[1] ? {i[0] ? 4'h7 : 4'h0, 8'h3c} : 12'h000;
            check("xfwa", rf_req.addr, x);
        end
        $display("test xor done");
    endtask
    task automatic t_skip;
        logic [2:0] e;
        slot({7'h33, 1'b1, 8'h10}, 8'h00, 8'h01, 1'b0);
        check("noskip", {discard, busy}, 2'b00);
        for (int n = 0; n < 2; n++) begin
            slot({7'h33, 1'b0, 8'h10}, 8'h00, 8'h00, n[0]);
            check("skip", {discard, busy, flag_upd.we}, 3'b110);
            slot(16'h0aff, 8'h00, 8'h00, n[0]);
            e = {n[0], n[0], 1'b0};
            check("skip2", {discard, busy, wreg_we}, e);
            if (n == 1) slot(16'h0aff, 8'h00, 8'h00, 1'b0);
            check("skipend", {discard, busy, wreg_we}, 3'b000);
        end
        $display("test skip done");
    endtask
    task automatic t_table;
        logic [3:0]  ops[11] = '{4'hb, 4'h8, 4'ha, 4'ha, 4'h9, 4'hf, 4'hd,
                                 4'he, 4'hc, 4'hb, 4'he};
        logic [20:0] p = 21'h00_0000;
        logic [7:0]  lat = 8'h00;
        logic [63:0] hx = 64'h0000_0000_0000_0000;
        foreach (ops[i]) begin
            slot({12'h000, ops[i]}, 8'h00, 8'h00, 1'b0);
            check("tbusy", {busy, flag_upd.we}, 2'b10);
            if (ops[i][1:0] == 2'h3) p = p + 21'h00_0001;
            if (ops[i][2]) hx[p[2:0] * 8 +: 8] = lat;
            else lat = p[0] ? p[8:1] ^ 8'ha5 : p[8:1];
            if (ops[i][1:0] == 2'h1) p = p + 21'h00_0001;
            if (ops[i][1:0] == 2'h2) p = p - 21'h00_0001;
            slot(16'h0aff, 8'h00, 8'h00, 1'b0);
            check("tptr", table_pointer, p);
            check("tlat", table_latch, lat);
            check("thold", hold_bytes, hx);
            check("tidle", {busy, wreg_we, flag_upd.we}, 3'b000);
        end
        $display("test table done");
    endtask
    // Main sequence and hang guard
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        t_xor();
        t_skip();
        t_table();
        complete_run();
    end
    initial begin
        #2_000_000;
        error_cnt++;
        complete_run();
    end
endmodule // taxe_exec_bench
